// File: rtl/rcos_pkg.sv
// Package for the recovered clock output select block: register map,
// field positions, reset values, counts and the carrier structs.
// Assumes one system clock domain; all pins are synchronised in the block.
package rcos_pkg;

	// Register offsets
	localparam logic [7:0] RCOS_CLOCK_CONTROL_ONE_OFS       = 8'h01;
	localparam logic [7:0] RCOS_INPUT_AND_OUTPUT_CONTROL_OFS = 8'h04;
	localparam logic [7:0] RCOS_CLOCK_RATIO_REPORT_OFS      = 8'h18;

	// Field positions in clock_control_one
	localparam int RCOS_SWAP_ENABLE_BIT = 7;
	localparam int RCOS_RATIO_SEL_BIT   = 0;

	// Field positions in input_and_output_control
	localparam int RCOS_RECOVERED_MASTER_CLOCK_DISABLE_BIT = 7;
	localparam int RCOS_RX_SEL_LSB       = 3;
	localparam int RCOS_TX_SEL_LSB       = 0;
	localparam int RCOS_SEL_W            = 3;

	// Values after reset
	localparam logic [7:0] RCOS_CTL1_RST  = 8'h00;
	localparam logic [7:0] RCOS_CTL4_RST  = 8'h00;
	localparam logic [7:0] RCOS_RATIO_RST = 8'h00;

	// Counts
	localparam int RCOS_LINE_COUNT   = 8;
	localparam int RCOS_SYNC_W       = RCOS_LINE_COUNT + 3;
	// Driven master clock rises per ratio window; ratio reads as 2.6 fixed point
	localparam int RCOS_RATIO_WIN    = 64;
	// Master clock rises per word clock half period at 256x and 128x
	localparam logic [7:0] RCOS_HALF_256 = 8'h80;
	localparam logic [7:0] RCOS_HALF_128 = 8'h40;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rcos_reg_req_s;

	typedef struct packed {
		logic       rvalid;
		logic [7:0] rdata;
	} rcos_reg_rsp_s;

	typedef struct packed {
		logic master_clk;
		logic master_clk_oe;
		logic word_clk;
		logic rx_line;
		logic tx_line;
		logic low_power;
	} rcos_clk_out_s;

endpackage

// File: rtl/rcos_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/10ps
module rcos_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} rcos_sync_s;

	rcos_sync_s state_ff;
	rcos_sync_s nxt_state;

	always_comb begin
		nxt_state.first  = async_i;
		nxt_state.second = state_ff.first;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign sync_o = state_ff.second;
endmodule

// File: rtl/rcos_top.sv
// Recovered master clock output select: line input multiplexer, clock
// ratio select, output disable, swap to the external clock on unlock,
// ratio measurement and serial word clock.
// Assumes pins are asynchronous to sys_clk_i and much slower than it.
// Pin clocks are sampled as levels, so each must stay below half
// of sys_clk_i; a faster clock aliases and the outputs lose edges.
// Contract
// - While reset is low the block is in low power and all state clears.
// - Eight positive line inputs pass an 8:2 mux set by register 04h.
// - With swap enabled, the external clock drives the output on unlock.
// - The ext/driven master clock ratio is measured and reported in 18h.
// - The output is 256x the sample rate, or 128x when 01h selects it.
// - The disable bit in 04h puts the master clock output in high-Z.
// - The serial word clock toggles at the output sample rate.
`timescale 1ns/10ps
module rcos_top
	import rcos_pkg::*;
#(
	parameter int LINES = rcos_pkg::RCOS_LINE_COUNT
) (
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_n_i,
	input  wire rcos_pkg::rcos_reg_req_s reg_req_i,
	output rcos_pkg::rcos_reg_rsp_s     reg_rsp_o,
	input  wire logic [LINES-1:0]       positive_line_inputs_i,
	input  wire logic                   pll_clk_256_i,
	input  wire logic                   pll_lock_i,
	input  wire logic                   external_system_clock_i,
	output rcos_pkg::rcos_clk_out_s     clk_out_o
);
	import rcos_pkg::*;

	typedef struct packed {
		// Software visible registers
		logic [7:0] ctl1;
		logic [7:0] ctl4;
		logic [7:0] ratio;
		// Read answer
		logic       rvalid;
		logic [7:0] rdata;
		// Clock selection
		logic       pll_prev;
		logic       div;
		logic       ext_prev;
		logic       mclk;
		logic       mclk_prev;
		// Ratio measurement
		logic [6:0] win_cnt;
		logic [8:0] ext_cnt;
		// Word clock
		logic [7:0] word_cnt;
		logic       word_clk;
		// Routed lines and status
		logic       rx_line;
		logic       tx_line;
		logic       low_power;
		logic       oe;
	} rcos_state_s;

	rcos_state_s       st_ff;
	rcos_state_s       nxt_st;
	logic [LINES+2:0]  pin_sync;
	logic [LINES-1:0]  line_s;
	logic              pll_s;
	logic              lock_s;
	logic              ext_s;

	// All pins share one synchroniser; each bit is an independent level
	rcos_sync #(
		.WIDTH(LINES + 3)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_n_i  (rst_n_i),
		.async_i  ({positive_line_inputs_i, pll_clk_256_i, pll_lock_i,
		            external_system_clock_i}),
		.sync_o   (pin_sync)
	);

	assign line_s = pin_sync[LINES+2:3];
	assign pll_s  = pin_sync[2];
	assign lock_s = pin_sync[1];
	assign ext_s  = pin_sync[0];

	// Picks a three bit select field out of input_and_output_control
	function automatic logic [RCOS_SEL_W-1:0] sel_field(
		input logic [7:0] reg_v,
		input int         lsb
	);
		sel_field = reg_v[lsb +: RCOS_SEL_W];
	endfunction

	// Edge detectors reset to zero, the idle level of every clock pin
	function automatic logic rising(input logic now, input logic prev);
		rising = now & ~prev;
	endfunction

	always_comb begin
		logic pll_rise;
		logic mclk_rise;
		logic sel_128;
		logic swap;
		logic [7:0] half;
		logic [8:0] ext_inc;
		pll_rise  = 1'b0;
		mclk_rise = 1'b0;
		sel_128   = 1'b0;
		swap      = 1'b0;
		half      = RCOS_HALF_256;
		ext_inc   = 9'h000;
		// Every field holds unless a branch below gives it a new value
		nxt_st    = st_ff;

		nxt_st.low_power = 1'b0;
		nxt_st.rvalid    = 1'b0;

		// 18h is read-only, so a write there is dropped like an unmapped one
		// Register writes; unmapped offsets are ignored
		if (reg_req_i.wr) begin
			if (reg_req_i.addr == RCOS_CLOCK_CONTROL_ONE_OFS) begin
				nxt_st.ctl1 = reg_req_i.wdata;
			end else if (reg_req_i.addr ==
			             RCOS_INPUT_AND_OUTPUT_CONTROL_OFS) begin
				nxt_st.ctl4 = reg_req_i.wdata;
			end
		end
		// Reads answer one cycle later; unmapped offsets read zero
		if (reg_req_i.rd) begin
			nxt_st.rvalid = 1'b1;
			unique case (reg_req_i.addr)
				RCOS_CLOCK_CONTROL_ONE_OFS:        nxt_st.rdata = st_ff.ctl1;
				RCOS_INPUT_AND_OUTPUT_CONTROL_OFS: nxt_st.rdata = st_ff.ctl4;
				RCOS_CLOCK_RATIO_REPORT_OFS:       nxt_st.rdata = st_ff.ratio;
				default:                           nxt_st.rdata = 8'h00;
			endcase
		end

		// Both selects index the synchronised lines, so routing lags the
		// pins by three clock edges
		// line input mux
		nxt_st.rx_line = line_s[sel_field(st_ff.ctl4, RCOS_RX_SEL_LSB)];
		nxt_st.tx_line = line_s[sel_field(st_ff.ctl4, RCOS_TX_SEL_LSB)];

		// 128x halves the PLL clock; the divider phase runs free
		// ratio select
		sel_128  = st_ff.ctl1[RCOS_RATIO_SEL_BIT];
		pll_rise = rising(pll_s, st_ff.pll_prev);
		nxt_st.pll_prev = pll_s;
		if (pll_rise) begin
			nxt_st.div = ~st_ff.div;
		end

		// Swap wins over the ratio select: the external clock passes as is
		// swap on unlock
		swap = st_ff.ctl1[RCOS_SWAP_ENABLE_BIT] & ~lock_s;
		if (swap) begin
			nxt_st.mclk = ext_s;
		end else if (sel_128) begin
			nxt_st.mclk = st_ff.div;
		end else begin
			nxt_st.mclk = pll_s;
		end

		// The window counts driven clock rises, so a swap reads near 1.0
		// ratio measured against the external clock
		nxt_st.ext_prev  = ext_s;
		nxt_st.mclk_prev = st_ff.mclk;
		mclk_rise = rising(st_ff.mclk, st_ff.mclk_prev);
		ext_inc   = st_ff.ext_cnt + {8'h00, rising(ext_s, st_ff.ext_prev)};
		if (ext_inc != 9'h1FF) begin
			nxt_st.ext_cnt = ext_inc;
		end
		if (mclk_rise) begin
			if (st_ff.win_cnt == 7'(RCOS_RATIO_WIN - 1)) begin
				nxt_st.win_cnt = 7'h00;
				nxt_st.ext_cnt = 9'h000;
				// Saturates rather than wraps so a fast reference reads max
				nxt_st.ratio   = ext_inc[8] ? 8'hFF : ext_inc[7:0];
			end else begin
				nxt_st.win_cnt = st_ff.win_cnt + 7'h01;
			end
		end

		// Counting driven rises keeps the word clock at the sample rate
		// at either ratio and across a swap
		// word clock from the master clock actually driven
		half = sel_128 ? RCOS_HALF_128 : RCOS_HALF_256;
		if (mclk_rise) begin
			if (st_ff.word_cnt >= half - 8'h01) begin
				nxt_st.word_cnt = 8'h00;
				nxt_st.word_clk = ~st_ff.word_clk;
			end else begin
				nxt_st.word_cnt = st_ff.word_cnt + 8'h01;
			end
		end

		// output disable, registered so the enable never glitches
		nxt_st.oe = ~nxt_st.ctl4[RCOS_RECOVERED_MASTER_CLOCK_DISABLE_BIT]
		            & ~nxt_st.low_power;
	end

	always_ff @(posedge sys_clk_i) begin
		// Low power marks the reset cycles and clears at the first edge after
		// reset clears all state
		if (!rst_n_i) begin
			st_ff           <= '0;
			st_ff.ctl1      <= RCOS_CTL1_RST;
			st_ff.ctl4      <= RCOS_CTL4_RST;
			st_ff.ratio     <= RCOS_RATIO_RST;
			st_ff.low_power <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rsp_o.rvalid = st_ff.rvalid;
	assign reg_rsp_o.rdata  = st_ff.rdata;

	// Every output comes straight from a flip-flop
	assign clk_out_o.master_clk    = st_ff.mclk;
	assign clk_out_o.master_clk_oe = st_ff.oe;
	assign clk_out_o.word_clk  = st_ff.word_clk;
	assign clk_out_o.rx_line   = st_ff.rx_line;
	assign clk_out_o.tx_line   = st_ff.tx_line;
	assign clk_out_o.low_power = st_ff.low_power;
endmodule

// File: dv/rcos_monitor.sv
// Checker bound to rcos_top: register answers, output enable, routing.
// Assumes it sees only the ports of rcos_top in one clock domain.
`timescale 1ns/10ps
module rcos_monitor
	import rcos_pkg::*;
#(
	parameter int LINES = 8
) (
	input wire logic                    sys_clk_i,
	input wire logic                    rst_n_i,
	input wire rcos_pkg::rcos_reg_req_s reg_req_i,
	input wire rcos_pkg::rcos_reg_rsp_s reg_rsp_o,
	input wire logic [LINES-1:0]        positive_line_inputs_i,
	input wire logic                    pll_clk_256_i,
	input wire logic                    pll_lock_i,
	input wire logic                    external_system_clock_i,
	input wire rcos_pkg::rcos_clk_out_s clk_out_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] c1_ff;
	logic [7:0] c4_ff;
	logic [2:0] pll_n_ff;
	logic [2:0] swp_n_ff;
	logic [2:0] c4_n_ff;
	// Counters wait out the pin synchronisers before clocks are compared
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			c1_ff <= 8'h00;
			c4_ff <= 8'h00;
		end else if (reg_req_i.wr && reg_req_i.addr == 8'h01) begin
			c1_ff <= reg_req_i.wdata & 8'h81;
		end else if (reg_req_i.wr && reg_req_i.addr == 8'h04) begin
			c4_ff <= reg_req_i.wdata & 8'hBF;
		end
		pll_n_ff <= (!rst_n_i || !pll_lock_i || c1_ff[0] || c4_ff[7]) ? 3'h0
			: pll_n_ff + 3'(pll_n_ff != 3'h7);
		swp_n_ff <= (!rst_n_i || pll_lock_i || !c1_ff[7] || c4_ff[7]) ? 3'h0
			: swp_n_ff + 3'(swp_n_ff != 3'h7);
		c4_n_ff <= (!rst_n_i || (reg_req_i.wr && reg_req_i.addr == 8'h04))
			? 3'h0 : c4_n_ff + 3'(c4_n_ff != 3'h7);
	end
	sequence s_rd(logic [7:0] a);
		reg_req_i.rd && reg_req_i.addr == a;
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n_i |=> clk_out_o.low_power && !clk_out_o.master_clk_oe)
		else $error("outputs not quiet in reset");
	a_read_answer: assert property (
		reg_req_i.rd |=> reg_rsp_o.rvalid) else $error("no read answer");
	a_ctl1_read: assert property (
		s_rd(8'h01) |=> (reg_rsp_o.rdata & 8'h81) == $past(c1_ff))
		else $error("ctl1 read wrong");
	a_ctl4_read: assert property (
		s_rd(8'h04) |=> (reg_rsp_o.rdata & 8'hBF) == $past(c4_ff))
		else $error("ctl4 read wrong");
	a_unmapped_zero: assert property (
		s_rd(8'h02) |=> reg_rsp_o.rdata == 8'h00) else $error("unmapped");
	a_hiz_hold: assert property (
		c4_ff[7] && $past(c4_ff[7]) |-> !clk_out_o.master_clk_oe)
		else $error("output driven while disabled");
	a_pll_follow: assert property (
		pll_n_ff == 3'h7 |-> clk_out_o.master_clk == $past(pll_clk_256_i, 3)
		|| clk_out_o.master_clk == $past(pll_clk_256_i, 4))
		else $error("master clock not from pll");
	a_swap_follow: assert property (
		swp_n_ff == 3'h7 |-> clk_out_o.master_clk ==
		$past(external_system_clock_i, 3) || clk_out_o.master_clk ==
		$past(external_system_clock_i, 4)) else $error("no clock swap");
	a_rx_route: assert property (
		c4_n_ff == 3'h7 |-> clk_out_o.rx_line ==
		$past(positive_line_inputs_i[c4_ff[5:3]], 3))
		else $error("receiver line not routed");
	a_tx_route: assert property (
		c4_n_ff == 3'h7 |-> clk_out_o.tx_line ==
		$past(positive_line_inputs_i[c4_ff[2:0]], 3))
		else $error("pass-through line not routed");
endmodule

// File: dv/rcos_clk_sink.sv
// Clock sink model: counts master clock rises per word clock half period.
// Assumes clk_out_i is registered in the sys_clk_i domain.
`timescale 1ns/10ps
module rcos_clk_sink (
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_n_i,
	input  wire rcos_pkg::rcos_clk_out_s clk_out_i,
	output logic [8:0]                   half_cnt_o
);
	import rcos_pkg::*;
	logic [8:0] cnt_ff;
	logic       mclk_ff;
	logic       wclk_ff;
	logic       rise;
	logic       flip;
	logic       pin;
	// A released pin has no pull; the model shows it inverted
	assign pin  = clk_out_i.master_clk_oe ? clk_out_i.master_clk
	                                      : !clk_out_i.master_clk;
	assign rise = pin && !mclk_ff;
	assign flip = wclk_ff != clk_out_i.word_clk;
	// A rise on the toggle cycle opens the new half, so counts stay exact
	always_ff @(posedge sys_clk_i) begin
		mclk_ff <= pin;
		wclk_ff <= clk_out_i.word_clk;
		cnt_ff <= !rst_n_i ? 9'h000 : (flip ? 9'h000 : cnt_ff) + 9'(rise);
		if (!rst_n_i)
			half_cnt_o <= 9'h000;
		else if (flip)
			half_cnt_o <= cnt_ff;
	end
endmodule

// File: dv/test_rcos_top.sv
// Bench for rcos_top: register tasks, pin stimulus and a clock sink.
// Assumes rcos_monitor and rcos_clk_sink are compiled before this file.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module test_rcos_top;
	import rcos_pkg::*;
	logic          sys_clk_i = 1'b0;
	logic          rst_n_i = 1'b0;
	rcos_reg_req_s req = '0;
	rcos_reg_rsp_s rsp;
	rcos_clk_out_s co;
	logic [7:0]    lines = 8'h00;
	logic          lock = 1'b1;
	logic [15:0]   cyc = 16'h0000;
	logic [8:0]    half;
	logic [7:0]    r_exp [3] = '{8'h40, 8'h20, 8'hFF};
	int            r_eh [3] = '{8, 16, 2};
	int            eh = 8;
	int            failures = 0;
	int            tests_run = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	always @(negedge sys_clk_i) cyc <= cyc + 16'h0001;
	rcos_top dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
		.reg_rsp_o(rsp), .positive_line_inputs_i(lines),
		.pll_clk_256_i(cyc[3]), .pll_lock_i(lock),
		.external_system_clock_i(cyc / eh % 2 == 1), .clk_out_o(co));
	rcos_clk_sink u_sink (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.clk_out_i(co), .half_cnt_o(half));
	task automatic results();
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge sys_clk_i);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req.rd = 1'b1;
		req.addr = a;
		@(negedge sys_clk_i);
		req.rd = 1'b0;
		`CHK(rsp.rvalid, 1'b1)
		`CHK(rsp.rdata, e)
		@(negedge sys_clk_i);
	endtask
	task automatic toggles(input int len, input int want);
		int   cnt;
		logic prv;
		cnt = 0;
		for (int k = 0; k < len; k++) begin
			prv = co.master_clk;
			@(negedge sys_clk_i);
			cnt += int'(prv !== co.master_clk);
		end
		`CHK(cnt, want)
	endtask
	initial begin
		// pin clocks run steady before release
		repeat (4) @(negedge sys_clk_i);
		`CHK({co.low_power, co.master_clk_oe}, 2'b10)
		rst_n_i = 1'b1;
		@(negedge sys_clk_i);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(8'h04, 8'(i * 8 + 7 - i));
			lines = 8'h01 << i;
			repeat (4) @(negedge sys_clk_i);
			`CHK({co.rx_line, co.tx_line}, 2'b10)
			lines = ~lines;
			repeat (4) @(negedge sys_clk_i);
			`CHK({co.rx_line, co.tx_line}, 2'b01)
		end
		wr(8'h04, 8'h80);
		rd(8'h04, 8'h80);
		`CHK(co.master_clk_oe, 1'b0)
		wr(8'h04, 8'h00);
		@(negedge sys_clk_i);
		`CHK(co.master_clk_oe, 1'b1)
		for (int i = 0; i < 3; i++) begin
			eh = r_eh[i];
			repeat (3500) @(negedge sys_clk_i);
			rd(8'h18, r_exp[i]);
		end
		eh = 8;
		repeat (3500) @(negedge sys_clk_i);
		wr(8'h18, 8'h00);
		rd(8'h18, 8'h40);
		`CHK(half, 9'h080)
		toggles(32, 4);
		wr(8'h01, 8'h01);
		rd(8'h01, 8'h01);
		repeat (6500) @(negedge sys_clk_i);
		`CHK(half, 9'h040)
		toggles(32, 2);
		wr(8'h01, 8'h00);
		lock = 1'b0;
		eh = 3;
		repeat (20) @(negedge sys_clk_i);
		toggles(32, 4);
		wr(8'h01, 8'h80);
		repeat (20) @(negedge sys_clk_i);
		toggles(12, 4);
		lock = 1'b1;
		repeat (20) @(negedge sys_clk_i);
		toggles(32, 4);
		results();
	end
endmodule
bind rcos_top rcos_monitor #(.LINES(LINES)) u_mon (
	.sys_clk_i              (sys_clk_i),
	.rst_n_i                (rst_n_i),
	.reg_req_i              (reg_req_i),
	.reg_rsp_o              (reg_rsp_o),
	.positive_line_inputs_i (positive_line_inputs_i),
	.pll_clk_256_i          (pll_clk_256_i),
	.pll_lock_i             (pll_lock_i),
	.external_system_clock_i(external_system_clock_i),
	.clk_out_o              (clk_out_o)
);
